// [caf_pkg.sv]
// package: register map, field layout and reset values of the acceptance filter configuration
package caf_pkg;
    localparam int unsigned ADDR_W          = 4;
    localparam int unsigned NUM_REGS        = 4;
    localparam int unsigned LANES           = 4;
    localparam int unsigned NUM_FILTERS     = NUM_REGS * LANES;
    localparam logic [3:0]  OFF_CTRL_0_3    = 4'h0;
    localparam logic [3:0]  OFF_CTRL_4_7    = 4'h4;
    localparam logic [3:0]  OFF_CTRL_8_11   = 4'h8;
    localparam logic [3:0]  OFF_CTRL_12_15  = 4'hc;
    localparam int unsigned ON_BIT          = 7;
    localparam int unsigned MASK_HI         = 6;
    localparam int unsigned MASK_LO         = 5;
    localparam int unsigned BUF_HI          = 4;
    localparam int unsigned BUF_LO          = 0;
    localparam logic [7:0]  LANE_RESET      = 8'h00;
    localparam logic [31:0] READ_UNMAPPED   = 32'h0000_0000;
endpackage

// [caf_lane.sv]
// one filter byte lane: enable, mask choice, buffer choice with reconfiguration lock
`timescale 1ns/1ps
`default_nettype none
module caf_lane
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_byte,
    output logic            filter_on,
    output logic [1:0]      mask_choice,
    output logic [4:0]      buffer_choice
);
    typedef struct packed {
        logic       on;
        logic [1:0] mask;
        logic [4:0] buff;
    } caf_lane_s;

    caf_lane_s st_q;
    caf_lane_s st_d;

    // =========================================================
    // next state
    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            st_d.on = wr_byte[caf_pkg::ON_BIT];
            // choices move only while the filter was disabled
            if (!st_q.on)
            begin
                st_d.mask = wr_byte[caf_pkg::MASK_HI:caf_pkg::MASK_LO];
                st_d.buff = wr_byte[caf_pkg::BUF_HI:caf_pkg::BUF_LO];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_q <= caf_lane_s'(caf_pkg::LANE_RESET);
        else
            st_q <= st_d;
    end

    assign filter_on     = st_q.on;
    assign mask_choice   = st_q.mask;
    assign buffer_choice = st_q.buff;

    // =========================================================
    // checks
    a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $past(st_q.on) && rst_n && $past(rst_n) |-> $stable({st_q.mask, st_q.buff}))
        else $error("choice changed while filter enabled");
    a_write_load: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && !st_q.on |=> {st_q.on, st_q.mask, st_q.buff} == $past(wr_byte))
        else $error("byte not loaded into disabled filter");
    a_on_follows: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en |=> st_q.on == $past(wr_byte[7]))
        else $error("enable did not follow write");
    a_idle_keep: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_en |=> $stable(st_q))
        else $error("lane changed without write");
    a_reset_clear: assert property (@(posedge clk)
        !rst_n |=> st_q == '0)
        else $error("lane not cleared by reset");
endmodule
`default_nettype wire

// [caf_regs.sv]
// one 32-bit filter control register built from four filter byte lanes
`timescale 1ns/1ps
`default_nettype none
module caf_regs
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    output logic [3:0]       filter_on,
    output logic [7:0]       mask_choice,
    output logic [19:0]      buffer_choice
);
    // =========================================================
    // lane k holds filter 4*index + k
    for (genvar k = 0; k < caf_pkg::LANES; k++)
    begin : g_lane
        caf_lane u_lane
        (
            .clk           (clk),
            .rst_n         (rst_n),
            .wr_en         (wr_en),
            .wr_byte       (wr_data[8*k +: 8]),
            .filter_on     (filter_on[k]),
            .mask_choice   (mask_choice[2*k +: 2]),
            .buffer_choice (buffer_choice[5*k +: 5])
        );
    end
endmodule
`default_nettype wire

// [caf_top.sv]
// top: register port and sixteen acceptance filter settings
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module caf_top
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    output logic [15:0]      filter_on,
    output logic [31:0]      mask_choice,
    output logic [79:0]      buffer_choice
);
    typedef struct packed {
        logic [31:0] rdata;
    } caf_top_s;

    caf_top_s    st_q;
    caf_top_s    st_d;
    logic [3:0]  wr_sel;
    logic [31:0] reg_img [caf_pkg::NUM_REGS];

    // =========================================================
    // write decode
    always_comb
    begin
        wr_sel = 4'h0;
        if (wr)
        begin
            case (addr)
                caf_pkg::OFF_CTRL_0_3:   wr_sel = 4'h1;
                caf_pkg::OFF_CTRL_4_7:   wr_sel = 4'h2;
                caf_pkg::OFF_CTRL_8_11:  wr_sel = 4'h4;
                caf_pkg::OFF_CTRL_12_15: wr_sel = 4'h8;
                default:                 wr_sel = 4'h0;
            endcase
        end
    end

    // =========================================================
    // registers
    for (genvar r = 0; r < caf_pkg::NUM_REGS; r++)
    begin : g_reg
        caf_regs u_regs
        (
            .clk           (clk),
            .rst_n         (rst_n),
            .wr_en         (wr_sel[r]),
            .wr_data       (wdata),
            .filter_on     (filter_on[4*r +: 4]),
            .mask_choice   (mask_choice[8*r +: 8]),
            .buffer_choice (buffer_choice[20*r +: 20])
        );
        for (genvar k = 0; k < caf_pkg::LANES; k++)
        begin : g_img
            assign reg_img[r][8*k +: 8] = {filter_on[4*r+k],
                                           mask_choice[8*r+2*k +: 2],
                                           buffer_choice[20*r+5*k +: 5]};
        end
    end

    // =========================================================
    // read path, data valid the cycle after the strobe
    always_comb
    begin
        st_d.rdata = caf_pkg::READ_UNMAPPED;
        if (rd)
        begin
            case (addr)
                caf_pkg::OFF_CTRL_0_3:   st_d.rdata = reg_img[0];
                caf_pkg::OFF_CTRL_4_7:   st_d.rdata = reg_img[1];
                caf_pkg::OFF_CTRL_8_11:  st_d.rdata = reg_img[2];
                caf_pkg::OFF_CTRL_12_15: st_d.rdata = reg_img[3];
                default:                 st_d.rdata = caf_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign rdata = st_q.rdata;

    // =========================================================
    // checks
    a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == 4'hc |=> rdata == $past(reg_img[3]))
        else $error("read data mismatch");
    a_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == 32'h0)
        else $error("read data not zero when idle");
    a_lock_top: assert property (@(posedge clk) disable iff (!rst_n)
        filter_on[12] && $past(rst_n) |=> $stable(buffer_choice[64:60]))
        else $error("filter 12 buffer changed while enabled");
endmodule
`default_nettype wire

// [caf_tb.sv]
// testbench: random and directed register traffic for the filter configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic         clk, rst_n, wr, rd, rd_chk;
    logic [3:0]   addr;
    logic [31:0]  wdata, rdata, mask_choice, rd_exp, r;
    logic [15:0]  filter_on;
    logic [79:0]  buffer_choice;
    logic [127:0] f_exp;
    logic [31:0]  m [4];
    int           error_cnt, compares, seed;

    caf_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .filter_on(filter_on), .mask_choice(mask_choice),
        .buffer_choice(buffer_choice));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========
    // model and compares
    function automatic logic [31:0] upd(input logic [31:0] o, input logic [31:0] d);
        for (int k = 0; k < 4; k++)
            upd[8*k+:8] = o[8*k+7] ? {d[8*k+7], o[8*k+:7]} : d[8*k+:8];
    endfunction

    task chk_rdata(input logic [31:0] e);
        compares++;
        if (rdata !== e)
        begin
            error_cnt++;
            $display("[FAIL] rdata expected %h seen %h", e, rdata);
        end
    endtask

    task chk_filters;
        logic [127:0] g;
        g = {filter_on, mask_choice, buffer_choice};
        compares++;
        if (g !== f_exp)
        begin
            error_cnt++;
            $display("[FAIL] filters expected %h seen %h", f_exp, g);
        end
    endtask

    always @(negedge clk)
        if (rst_n === 1'b1)
        begin
            for (int n = 0; n < 16; n++)
            begin
                f_exp[112+n] = m[n/4][8*(n%4)+7];
                f_exp[80+2*n+:2] = m[n/4][8*(n%4)+5+:2];
                f_exp[5*n+:5] = m[n/4][8*(n%4)+:5];
            end
            chk_filters();
            chk_rdata(rd_chk ? rd_exp : 32'h0);
        end

    // ==========
    // bus tasks, called just after a rising edge
    task op(input logic w, input logic rr, input logic [3:0] a, input logic [31:0] d);
        wr <= w;
        rd <= rr;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        rd_exp = (a[1:0] == 2'h0) ? m[a[3:2]] : caf_pkg::READ_UNMAPPED;
        if (w && a[1:0] == 2'h0)
            m[a[3:2]] = upd(m[a[3:2]], d);
        rd_chk = rr;
    endtask

    task do_reset;
        rst_n <= 1'b0;
        wr <= 1'b0;
        rd <= 1'b0;
        rd_chk = 1'b0;
        for (int k = 0; k < 4; k++)
            m[k] = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task print_verdict;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    // ==========
    // main sequence
    initial
    begin
        seed = 99178;
        {wr, rd, addr, wdata, rst_n, rd_chk} = '0;
        do_reset();
        for (int i = 0; i < 4; i++)
            op(1'b0, 1'b1, 4'(4*i), 32'h0);
        op(1'b1, 1'b0, 4'h4, 32'h0000009f);
        op(1'b0, 1'b1, 4'h4, 32'h0);
        op(1'b1, 1'b0, 4'hc, 32'h7f5f3f1f);
        op(1'b1, 1'b0, 4'hc, 32'h80a0c0e0);
        op(1'b1, 1'b0, 4'hc, 32'hffffffff);
        op(1'b1, 1'b0, 4'hc, 32'h1f1f1f1f);
        op(1'b1, 1'b0, 4'hc, 32'h00000000);
        op(1'b0, 1'b1, 4'hc, 32'h0);
        op(1'b1, 1'b0, 4'h2, 32'hffffffff);
        op(1'b0, 1'b1, 4'h2, 32'h0);
        repeat (600)
        begin
            r = $random(seed);
            op(r[9], ~r[9] & r[8], (r[7:4] == 4'h0) ? r[3:0] : {r[3:2], 2'h0}, $random(seed));
        end
        do_reset();
        op(1'b0, 1'b1, 4'h4, 32'h0);
        op(1'b0, 1'b0, 4'h0, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
